// File: mrs_consts.vh
// Constants for the measurement readout and scaling block
`ifndef MRS_CONSTS_VH
`define MRS_CONSTS_VH
// Identifier bases, added to the node number
`define MRS_ID_REQ_BASE 11'h600
`define MRS_ID_RSP_BASE 11'h580
// Command bytes
`define MRS_CMD_UPLOAD 8'h40
`define MRS_CMD_UPLOAD_RSP4 8'h43
`define MRS_CMD_DNLOAD4 8'h22
`define MRS_CMD_DNLOAD4_SIZED 8'h23
`define MRS_CMD_DNLOAD_ACK 8'h60
`define MRS_CMD_ABORT 8'h80
`define MRS_ABORT_NO_OBJECT 32'h06020000
// Object indices and sub-indices
`define MRS_IDX_LOWER 16'h6121
`define MRS_IDX_UPPER 16'h6123
`define MRS_IDX_PROCESS 16'h6130
`define MRS_IDX_FIELD 16'h7100
`define MRS_SUB_PRIMARY 8'h01
`define MRS_SUB_SECONDARY 8'h02
// Frame field positions (byte 0 in bits 7:0)
`define MRS_F_CMD 7:0
`define MRS_F_IDX 23:8
`define MRS_F_SUB 31:24
`define MRS_F_VAL 63:32
// Volatile scaling reset values (float32)
`define MRS_PRI_LOWER_RST 32'h00000000
`define MRS_PRI_UPPER_RST 32'h469C4000
`define MRS_SEC_LOWER_RST 32'hC25C0000
`define MRS_SEC_UPPER_RST 32'h42FA0000
// 1/20000 as float32, the fixed span divisor
`define MRS_INV_SPAN 32'h3851B717
`endif

// File: mrs_readout.v
// Measurement readout over expedited SDO with per-channel float scaling
//
// Notes on behaviour
// - The scaling span is always 0..20000 counts; no setting alters that span.
// - Field values are sent raw: no scaling, clamping or decimal shift.
// - Each field value is a signed 16-bit integer.
// - Negative readings leave in two's complement, e.g. 0xFFF3 is -13.
// - Field answer on 0x580+node, command 43, value LSB first unless MSB_FIRST, two zeros.
// - Secondary temperature channel exists on pressure variants only.
// - Float answer: command 43, echoed index and sub, four value bytes.
// - Float process values are IEEE-754 single precision.
// - Secondary default maps 0..20000 onto -55..+125 degrees Celsius.
// - Each channel's process value is rescaled by its own limits.
// - Lower limit at 0x6121, upper at 0x6123, both float32.
// - Sub-index 01 selects primary, 02 selects secondary channel.
// - Accepted limit write acknowledged with command 60 and zero data.
// - Limits live in volatile flip-flops, lost at reset or power loss.
// - Byte order of measurement values selectable, LSB or MSB first.
`timescale 1ns/10ps
`include "mrs_consts.vh"

module mrs_readout
(
    CLK,
    RESET,
    NODE_ID,
    PRESSURE_VARIANT,
    MSB_FIRST,
    PRI_RAW,
    SEC_RAW,
    REQ_VALID,
    REQ_ID,
    REQ_DATA,
    BUSY,
    RSP_VALID,
    RSP_ID,
    RSP_DATA
);
    input wire CLK;
    input wire RESET;
    input wire [6:0] NODE_ID;
    input wire PRESSURE_VARIANT;
    input wire MSB_FIRST;
    input wire [15:0] PRI_RAW;
    input wire [15:0] SEC_RAW;
    input wire REQ_VALID;
    input wire [10:0] REQ_ID;
    input wire [63:0] REQ_DATA;
    output reg BUSY;
    output reg RSP_VALID;
    output reg [10:0] RSP_ID;
    output reg [63:0] RSP_DATA;

    localparam ST_IDLE = 3'h0;
    localparam ST_CONV = 3'h1;
    localparam ST_MUL = 3'h2;
    localparam ST_DIV = 3'h3;
    localparam ST_ADD = 3'h4;

    // Signed 16-bit count to float32, exact for every input
    function [31:0] int_to_float;
        input [15:0] v;
        reg [15:0] m;
        reg [4:0] p;
        reg [38:0] t;
        integer i;
        begin
            m = v[15] ? (~v + 16'h0001) : v;
            p = 5'h00;
            for (i = 0; i < 16; i = i + 1)
                if (m[i])
                    p = i[4:0];
            t = {23'h000000, m} << (6'h17 - {1'b0, p});
            if (m == 16'h0000)
                int_to_float = 32'h00000000;
            else
                int_to_float = {v[15], 8'h7F + {3'h0, p}, t[22:0]};
        end
    endfunction

    // Float32 multiply; truncates, flushes tiny results to zero
    function [31:0] fmul;
        input [31:0] a;
        input [31:0] b;
        reg s;
        reg [47:0] prod;
        reg [9:0] e;
        reg [22:0] mant;
        begin
            s = a[31] ^ b[31];
            prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
            e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - 10'h07F;
            if (prod[47])
            begin
                mant = prod[46:24];
                e = e + 10'h001;
            end
            else
                mant = prod[45:23];
            if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e[9] ||
                e == 10'h000)
                fmul = 32'h00000000;
            else if (e >= 10'h0FF)
                fmul = {s, 8'hFF, 23'h000000};
            else
                fmul = {s, e[7:0], mant};
        end
    endfunction

    // Float32 add; truncates, no denormals
    function [31:0] fadd;
        input [31:0] a_in;
        input [31:0] b_in;
        reg [31:0] a;
        reg [31:0] b;
        reg [7:0] d;
        reg [26:0] x;
        reg [26:0] y;
        reg [26:0] sum;
        reg [26:0] n;
        reg [4:0] p;
        reg [9:0] e;
        integer i;
        begin
            if (a_in[30:0] < b_in[30:0])
            begin
                a = b_in;
                b = a_in;
            end
            else
            begin
                a = a_in;
                b = b_in;
            end
            d = a[30:23] - b[30:23];
            x = {2'h1, a[22:0], 2'h0};
            y = (d > 8'h1A) ? 27'h0000000 : ({2'h1, b[22:0], 2'h0} >> d);
            sum = (a[31] == b[31]) ? (x + y) : (x - y);
            p = 5'h00;
            for (i = 0; i < 27; i = i + 1)
                if (sum[i])
                    p = i[4:0];
            n = sum << (5'h1A - p);
            e = {2'h0, a[30:23]} + {5'h00, p} - 10'h019;
            if (b[30:23] == 8'h00)
                fadd = a;
            else if (sum == 27'h0000000 || e[9] || e == 10'h000)
                fadd = 32'h00000000;
            else if (e >= 10'h0FF)
                fadd = {a[31], 8'hFF, 23'h000000};
            else
                fadd = {a[31], e[7:0], n[25:3]};
        end
    endfunction

    // Value bytes of a response in the selected order
    function [31:0] order32;
        input [31:0] v;
        input msb;
        begin
            order32 = msb ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
        end
    endfunction

    reg [2:0] state_r;
    reg [31:0] lower_r [0:1];
    reg [31:0] upper_r [0:1];
    reg [31:0] acc_r;
    reg [31:0] span_r;
    reg [15:0] raw_r;
    reg chan_r;
    reg [31:0] hdr_r;

    wire [10:0] own_req_id = `MRS_ID_REQ_BASE + {4'h0, NODE_ID};
    wire [10:0] own_rsp_id = `MRS_ID_RSP_BASE + {4'h0, NODE_ID};
    wire [7:0] req_cmd = REQ_DATA[`MRS_F_CMD];
    wire [15:0] req_idx = REQ_DATA[`MRS_F_IDX];
    wire [7:0] req_sub = REQ_DATA[`MRS_F_SUB];
    wire sub_is_sec = (req_sub == `MRS_SUB_SECONDARY);
    wire chan_ok = (req_sub == `MRS_SUB_PRIMARY) ||
                   (sub_is_sec && PRESSURE_VARIANT);
    wire is_upload = (req_cmd == `MRS_CMD_UPLOAD);
    wire is_dnload = (req_cmd == `MRS_CMD_DNLOAD4) ||
                     (req_cmd == `MRS_CMD_DNLOAD4_SIZED);
    wire is_limit = (req_idx == `MRS_IDX_LOWER) ||
                    (req_idx == `MRS_IDX_UPPER);
    wire is_lower = (req_idx == `MRS_IDX_LOWER);
    wire [15:0] field_raw = sub_is_sec ? SEC_RAW : PRI_RAW;
    wire [31:0] limit_val = is_lower ? lower_r[sub_is_sec] :
                                       upper_r[sub_is_sec];
    wire take = (state_r == ST_IDLE) && REQ_VALID && (REQ_ID == own_req_id);

    always @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state_r <= ST_IDLE;
            // Defaults only; nothing is kept across reset
            lower_r[0] <= `MRS_PRI_LOWER_RST;
            upper_r[0] <= `MRS_PRI_UPPER_RST;
            lower_r[1] <= `MRS_SEC_LOWER_RST;
            upper_r[1] <= `MRS_SEC_UPPER_RST;
            acc_r <= 32'h00000000;
            span_r <= 32'h00000000;
            raw_r <= 16'h0000;
            chan_r <= 1'b0;
            hdr_r <= 32'h00000000;
            BUSY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_ID <= 11'h000;
            RSP_DATA <= 64'h0000000000000000;
        end
        else
        begin
            RSP_VALID <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        RSP_ID <= own_rsp_id;
                        hdr_r <= {req_sub, req_idx, `MRS_CMD_UPLOAD_RSP4};
                        chan_r <= sub_is_sec;
                        raw_r <= field_raw;
                        if (is_upload && req_idx == `MRS_IDX_FIELD && chan_ok)
                        begin
                            // Raw count, no scaling or clamp
                            RSP_VALID <= 1'b1;
                            RSP_DATA <= {order32({16'h0000, field_raw},
                                                 MSB_FIRST) >>
                                         (MSB_FIRST ? 16 : 0),
                                         req_sub, req_idx,
                                         `MRS_CMD_UPLOAD_RSP4};
                        end
                        else if (is_upload && req_idx == `MRS_IDX_PROCESS &&
                                 chan_ok)
                        begin
                            BUSY <= 1'b1;
                            state_r <= ST_CONV;
                        end
                        else if (is_upload && is_limit && chan_ok)
                        begin
                            RSP_VALID <= 1'b1;
                            RSP_DATA <= {order32(limit_val, MSB_FIRST),
                                         req_sub, req_idx,
                                         `MRS_CMD_UPLOAD_RSP4};
                        end
                        else if (is_dnload && is_limit && chan_ok)
                        begin
                            // Limit arrives LSB first
                            if (is_lower)
                                lower_r[sub_is_sec] <= REQ_DATA[`MRS_F_VAL];
                            else
                                upper_r[sub_is_sec] <= REQ_DATA[`MRS_F_VAL];
                            RSP_VALID <= 1'b1;
                            RSP_DATA <= {32'h00000000, req_sub, req_idx,
                                         `MRS_CMD_DNLOAD_ACK};
                        end
                        else
                        begin
                            RSP_VALID <= 1'b1;
                            RSP_DATA <= {`MRS_ABORT_NO_OBJECT, req_sub,
                                         req_idx, `MRS_CMD_ABORT};
                        end
                    end
                end
                ST_CONV:
                begin
                    // Span first, so one adder and two multiplies follow
                    acc_r <= int_to_float(raw_r);
                    span_r <= fadd(upper_r[chan_r],
                                   {~lower_r[chan_r][31],
                                    lower_r[chan_r][30:0]});
                    state_r <= ST_MUL;
                end
                ST_MUL:
                begin
                    acc_r <= fmul(acc_r, span_r);
                    state_r <= ST_DIV;
                end
                ST_DIV:
                begin
                    // Multiply by 1/20000; avoids a float divider
                    acc_r <= fmul(acc_r, `MRS_INV_SPAN);
                    state_r <= ST_ADD;
                end
                ST_ADD:
                begin
                    RSP_VALID <= 1'b1;
                    RSP_DATA <= {order32(fadd(lower_r[chan_r], acc_r),
                                         MSB_FIRST),
                                 hdr_r};
                    BUSY <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default:
                begin
                    BUSY <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: mrs_readout_sva.sv
// Assertion checker for the measurement readout block
`timescale 1ns/10ps
`include "mrs_consts.vh"
module mrs_readout_sva
(
    input logic CLK,
    input logic RESET,
    input logic [6:0] NODE_ID,
    input logic PRESSURE_VARIANT,
    input logic MSB_FIRST,
    input logic [15:0] PRI_RAW,
    input logic [15:0] SEC_RAW,
    input logic REQ_VALID,
    input logic [10:0] REQ_ID,
    input logic [63:0] REQ_DATA,
    input logic BUSY,
    input logic RSP_VALID,
    input logic [10:0] RSP_ID,
    input logic [63:0] RSP_DATA
);
    wire tk = REQ_VALID && !BUSY && REQ_ID == `MRS_ID_REQ_BASE + NODE_ID;
    wire rd = tk && REQ_DATA[7:0] == `MRS_CMD_UPLOAD;
    wire s1 = REQ_DATA[31:24] == `MRS_SUB_PRIMARY;
    wire s2 = REQ_DATA[31:24] == `MRS_SUB_SECONDARY;
    wire fld = rd && REQ_DATA[23:8] == `MRS_IDX_FIELD;
    wire prc = rd && REQ_DATA[23:8] == `MRS_IDX_PROCESS;
    wire wr = tk && REQ_DATA[7:0] == `MRS_CMD_DNLOAD4 &&
        (s1 || (s2 && PRESSURE_VARIANT)) &&
        (REQ_DATA[23:8] == `MRS_IDX_LOWER || REQ_DATA[23:8] == `MRS_IDX_UPPER);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_field_answer: assert property (fld && s1 |=> RSP_VALID &&
        RSP_DATA[31:0] == {$past(REQ_DATA[31:8]), `MRS_CMD_UPLOAD_RSP4})
        else $error("field answer header wrong");
    a_field_raw: assert property (fld && s1 && !MSB_FIRST |=>
        RSP_DATA[63:32] == {16'h0000, $past(PRI_RAW)})
        else $error("field value not raw");
    a_field_swap: assert property (fld && s1 && MSB_FIRST |=>
        RSP_DATA[63:32] == {16'h0000, $past(PRI_RAW[7:0]),
        $past(PRI_RAW[15:8])}) else $error("field byte order wrong");
    a_sec_field: assert property (fld && s2 && PRESSURE_VARIANT &&
        !MSB_FIRST |=> RSP_DATA[63:32] == {16'h0000, $past(SEC_RAW)})
        else $error("secondary field value wrong");
    a_rsp_ident: assert property (RSP_VALID |->
        RSP_ID == `MRS_ID_RSP_BASE + NODE_ID) else $error("answer id wrong");
    a_float_late: assert property (prc && s2 && PRESSURE_VARIANT
        |=> BUSY [*4] ##1 (RSP_VALID && !BUSY && RSP_DATA[31:0] ==
        {`MRS_SUB_SECONDARY, `MRS_IDX_PROCESS, `MRS_CMD_UPLOAD_RSP4}))
        else $error("float answer timing wrong");
    a_write_ack: assert property (wr |=> RSP_VALID && RSP_DATA ==
        {32'h0, $past(REQ_DATA[31:8]), `MRS_CMD_DNLOAD_ACK})
        else $error("write acknowledge wrong");
    a_absent_abort: assert property (rd && s2 && !PRESSURE_VARIANT
        |-> ##[1:4] RSP_VALID && RSP_DATA[7:0] == `MRS_CMD_ABORT)
        else $error("missing channel not refused");
    c_field: cover property (fld);
    c_write: cover property (wr);
    c_float: cover property (prc && PRESSURE_VARIANT);
endmodule
bind mrs_readout mrs_readout_sva u_mrs_readout_sva (.CLK, .RESET, .NODE_ID,
    .PRESSURE_VARIANT, .MSB_FIRST, .PRI_RAW, .SEC_RAW, .REQ_VALID, .REQ_ID,
    .REQ_DATA, .BUSY, .RSP_VALID, .RSP_ID, .RSP_DATA);

// File: mrs_master.sv
// Bus master model that issues expedited transfer requests
`timescale 1ns/10ps
module mrs_master
(
    input logic CLK,
    output logic REQ_VALID,
    output logic [10:0] REQ_ID,
    output logic [63:0] REQ_DATA
);
    initial
    begin
        REQ_VALID = 1'b0;
        REQ_ID = 11'h000;
        REQ_DATA = 64'h0;
    end
    // Idle lines show the inverted frame, so a stale copy cannot pass
    task send(input logic [10:0] id, input logic [63:0] d);
        @(posedge CLK);
        REQ_VALID <= 1'b1;
        REQ_ID <= id;
        REQ_DATA <= d;
        @(posedge CLK);
        REQ_VALID <= 1'b0;
        REQ_ID <= ~id;
        REQ_DATA <= ~d;
    endtask
endmodule

// File: mrs_readout_bench.sv
// Testbench for the measurement readout block
`timescale 1ns/10ps
module mrs_readout_bench;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic PRESSURE_VARIANT = 1'b1;
    logic MSB_FIRST = 1'b0;
    logic [6:0] NODE_ID = 7'h05;
    logic [15:0] PRI_RAW = 16'hFFF3;
    logic [15:0] SEC_RAW = 16'h2710;
    logic REQ_VALID, BUSY, RSP_VALID;
    logic [10:0] REQ_ID, RSP_ID;
    logic [63:0] REQ_DATA, RSP_DATA;
    int error_cnt = 0;
    int total_checks = 0;
    mrs_readout u_mrs_readout (.CLK, .RESET, .NODE_ID, .PRESSURE_VARIANT,
        .MSB_FIRST, .PRI_RAW, .SEC_RAW, .REQ_VALID, .REQ_ID, .REQ_DATA,
        .BUSY, .RSP_VALID, .RSP_ID, .RSP_DATA);
    mrs_master u_mrs_master (.CLK, .REQ_VALID, .REQ_ID, .REQ_DATA);
    initial
    begin
        forever #50 CLK = ~CLK;
    end
    task test_done;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Float results may differ by a few ULP, the divide is a truncated multiply
    task xfer(input logic [63:0] q, input logic [63:0] e, input int tol);
        logic [31:0] v;
        int n;
        int d;
        u_mrs_master.send(11'h600 + {4'h0, NODE_ID}, q);
        n = 0;
        @(negedge CLK);
        while (RSP_VALID !== 1'b1 && n < 8)
        begin
            @(negedge CLK);
            n++;
        end
        v = RSP_DATA[63:32];
        if (tol > 0 && MSB_FIRST)
            v = {RSP_DATA[39:32], RSP_DATA[47:40], RSP_DATA[55:48],
                RSP_DATA[63:56]};
        d = int'(v) - int'(e[63:32]);
        total_checks++;
        if (RSP_VALID !== 1'b1 || RSP_ID !== 11'h580 + {4'h0, NODE_ID} ||
            RSP_DATA[31:0] !== e[31:0] || (tol == 0 ? v !== e[63:32] :
            (^v === 1'bx || d > tol || d < -tol)))
        begin
            error_cnt++;
            $display("wrong value at %0t: sent %h got %h", $time, q, RSP_DATA);
        end
    endtask
    initial
    begin
        repeat (20) @(posedge CLK);
        RESET <= 1'b0;
        xfer(64'h0_01710040, 64'h0000FFF3_01710043, 0);
        @(posedge CLK) MSB_FIRST <= 1'b1;
        xfer(64'h0_01710040, 64'h0000F3FF_01710043, 0);
        xfer(64'h0_02613040, 64'h420C0000_02613043, 4);
        @(posedge CLK) MSB_FIRST <= 1'b0;
        xfer(64'h0_02710040, 64'h00002710_02710043, 0);
        xfer(64'h0_02612122, 64'h0_02612160, 0);
        xfer(64'h459C4000_02612322, 64'h0_02612360, 0);
        xfer(64'h459C4000_01612322, 64'h0_01612360, 0);
        xfer(64'h0_02612340, 64'h459C4000_02612343, 0);
        xfer(64'h0_02612123, 64'h0_02612160, 0);
        @(posedge CLK) PRI_RAW <= 16'h4E20;
        SEC_RAW <= 16'h0FA0;
        xfer(64'h0_02613040, 64'h447A0000_02613043, 4);
        xfer(64'h0_01613040, 64'h459C4000_01613043, 4);
        xfer(64'h0_01710040, 64'h00004E20_01710043, 0);
        @(posedge CLK) PRESSURE_VARIANT <= 1'b0;
        xfer(64'h0_02613040, 64'h06020000_02613080, 0);
        @(posedge CLK) RESET <= 1'b1;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        PRESSURE_VARIANT <= 1'b1;
        xfer(64'h0_02613040, 64'hC1980000_02613043, 4);
        test_done;
    end
    initial
    begin
        repeat (2000) @(posedge CLK);
        error_cnt++;
        test_done;
    end
endmodule
